// >>> logic/rcp_parser.sv
// Remote command parser: tokenizer, tree walk, responses, local/remote and service request
// How it works
// - Service request line is high while any enabled status condition other than bit 6 exists.
// - A serial poll returns the status byte with the request bit.
// - Reset leaves the device local; panel keys and bus commands both work.
// - Remote state blocks panel keys except return, which goes back to local.
// - Remote state lights the remote indicator on the display.
// - All traffic is ASCII characters, numbers and strings alike.
// - New message before response is read flushes it and flags query interrupted.
// - Numbers are classed as plain integer, decimal point, or exponent form.
// - Boolean parameters are only the words ON or OFF.
// - Character responses are cut at twelve characters; strings are unlimited.
// - Header letters match regardless of case.
// - Headers starting with an asterisk decode as common commands.
// - Only exact short or exact long header forms are accepted.
// - A colon separates header levels inside one command.
// - Parameter data follows the header after at least one space.
// - Optional tree nodes may be skipped and the command still resolves.
// - Message units are separated by semicolons; zero units is legal.
// - A message ends on EOI alone, newline alone, or newline with EOI.
// - Responses end with newline plus EOI on the parallel bus, newline alone serially.
// - First unit of each message resolves from the root.
// - Later units start at the previous level; a leading colon returns to root.
// - Units run on arrival; a coupled non-query unit is held until the next coupled non-query unit or the terminator.
`timescale 1ns/100ps
module rcp_parser (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire rcp_pkg::rcp_rx_t   rx,
  output logic                    rx_ready_q,
  output rcp_pkg::rcp_cmd_t       cmd_q,
  output logic                    cmd_err_q,
  output logic                    query_int_q,
  input  wire rcp_pkg::rcp_resp_t resp,
  output logic                    resp_ready_q,
  output rcp_pkg::rcp_tx_t        tx_q,
  input  wire logic               tx_ready,
  input  wire logic               serial_mode,
  input  wire logic [7:0]         status_byte,
  input  wire logic [7:0]         srq_enable,
  input  wire logic               poll_req,
  output logic [7:0]              poll_data_q,
  output logic                    poll_valid_q,
  output logic                    srq_q,
  input  wire logic               go_remote,
  input  wire logic               go_local,
  input  wire logic [7:0]         panel_keys,
  input  wire logic               key_return,
  output logic [7:0]              panel_keys_q,
  output logic                    remote_q,
  output logic                    remote_ind_q
);
  import rcp_pkg::*;

  // Case folding of a header or data character
  function automatic logic [7:0] to_upper(input logic [7:0] c);
    return (c >= 8'h61 && c <= 8'h7a) ? (c - 8'h20) : c;
  endfunction

  // Character i of keyword k, counted from its first letter
  function automatic logic [7:0] kw_char(input int k, input logic [3:0] i);
    logic [6:0] sh;
    sh = 7'(8 * (RCP_KW[k].llen - 4'h1 - i));
    return RCP_KW[k].name[sh +: 8];
  endfunction

  // Node that may be reached from level lv, directly or through an optional node
  function automatic logic reach(input logic [3:0] p, input logic [3:0] lv);
    logic r;
    r = (p == lv);
    for (int j = 1; j <= RCP_NKW; j++) begin
      if (p == 4'(j) && RCP_KW[j].opt && RCP_KW[j].parent == lv) begin
        r = 1'b1;
      end
    end
    return r;
  endfunction

  // Parent of a node, root for the root
  function automatic logic [3:0] parent_of(input logic [3:0] n);
    logic [3:0] p;
    p = RCP_ROOT;
    for (int j = 1; j <= RCP_NKW; j++) begin
      if (n == 4'(j)) begin
        p = RCP_KW[j].parent;
      end
    end
    return p;
  endfunction

  rcp_pstate_t        st_q, st_d;
  logic [RCP_NKW:1]   hit_q, hit_d;
  logic [3:0]         len_q, len_d, node_q, node_d, level_q, level_d;
  logic               msg_start_q, msg_start_d, eoi_pend_q, eoi_pend_d, rel_q, rel_d;
  logic               query_q, query_d, common_q, common_d;
  logic [23:0]        code_q, code_d;
  logic               pdig_q, pdig_d, pdot_q, pdot_d, pexp_q, pexp_d, pnum_q, pnum_d, pprev_e_q, pprev_e_d;
  logic [3:0]         plen_q, plen_d;
  logic [23:0]        pword_q, pword_d;
  rcp_cmd_t           pend_q, pend_d, cmd_d;
  logic               cmd_err_d, query_int_d, rx_ready_d;
  rcp_tstate_t        tst_q, tst_d;
  logic [RCP_BUF_AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [4:0]         cnt_q, cnt_d, crd_q, crd_d;
  logic               done_q, done_d, resp_ready_d, we;
  logic [7:0]         rdata_q;
  rcp_tx_t            tx_d;
  logic [7:0]         keys_s1_q, keys_s2_q;
  logic [2:0]         ret_q, ser_q;

  // Parser next state
  always_comb begin
    logic       v, term, found, feed, fin, bad, resp_busy;
    logic [7:0] d, c;
    logic [3:0] fidx;
    rcp_cmd_t   nu;
    v = rx.valid || eoi_pend_q;
    d = eoi_pend_q ? RCP_NL : rx.data;
    c = to_upper(d);
    term = v && d == RCP_NL;
    st_d = st_q; hit_d = hit_q; len_d = len_q; node_d = node_q; level_d = level_q;
    msg_start_d = msg_start_q; query_d = query_q; common_d = common_q; code_d = code_q;
    pdig_d = pdig_q; pdot_d = pdot_q; pexp_d = pexp_q; pnum_d = pnum_q; pprev_e_d = pprev_e_q;
    plen_d = plen_q; pword_d = pword_q; pend_d = pend_q; cmd_d = '0;
    cmd_err_d = 1'b0; query_int_d = 1'b0; feed = 1'b0; fin = 1'b0; bad = 1'b0; nu = '0;
    eoi_pend_d = rx.valid && rx.eoi && rx.data != RCP_NL;
    rx_ready_d = !eoi_pend_d;
    rel_d = 1'b0;
    resp_busy = cnt_q != 5'h00 || done_q || tst_q != RCP_T_IDLE;
    // Header resolution against the current tree level
    found = 1'b0;
    fidx = RCP_ROOT;
    for (int k = RCP_NKW; k >= 1; k--) begin
      if (hit_q[k] && (len_q == RCP_KW[k].slen || len_q == RCP_KW[k].llen)
          && reach(RCP_KW[k].parent, node_q)) begin
        found = 1'b1;
        fidx = 4'(k);
      end
    end
    if (v && msg_start_q && resp_busy) begin
      query_int_d = 1'b1;
    end
    if (v) begin
      msg_start_d = 1'b0;
      case (st_q)
        RCP_P_START: begin
          hit_d = '1; len_d = 4'h0; query_d = 1'b0; common_d = 1'b0; code_d = '0;
          pdig_d = 1'b0; pdot_d = 1'b0; pexp_d = 1'b0; pnum_d = 1'b1; pprev_e_d = 1'b0;
          plen_d = 4'h0; pword_d = '0;
          node_d = msg_start_q ? RCP_ROOT : level_q;
          if (d == RCP_COLON) begin
            node_d = RCP_ROOT;
            st_d = RCP_P_HDR;
          end else if (d == RCP_STAR) begin
            common_d = 1'b1;
            st_d = RCP_P_HDR;
          end else if (d != RCP_SP && d != RCP_SEMI && !term) begin
            feed = 1'b1;
            st_d = RCP_P_HDR;
          end
        end
        RCP_P_HDR: begin
          if (d == RCP_SEMI || term) begin
            fin = 1'b1;
          end else if (d == RCP_QM) begin
            query_d = 1'b1;
          end else if (common_q) begin
            if (d == RCP_SP) begin
              st_d = RCP_P_SP;
            end else begin
              code_d = {code_q[15:0], c};
            end
          end else if (d == RCP_COLON || d == RCP_SP) begin
            if (found) begin
              node_d = fidx;
              hit_d = '1;
              len_d = 4'h0;
              st_d = (d == RCP_SP) ? RCP_P_SP : RCP_P_HDR;
            end else begin
              bad = 1'b1;
            end
          end else begin
            feed = 1'b1;
          end
        end
        RCP_P_SP, RCP_P_DATA: begin
          if (d == RCP_SEMI || term) begin
            fin = 1'b1;
          end else if (d != RCP_SP) begin
            // Parameter classification
            st_d = RCP_P_DATA;
            plen_d = plen_q + 4'h1;
            pword_d = {pword_q[15:0], c};
            pprev_e_d = 1'b0;
            if (c >= 8'h30 && c <= 8'h39) begin
              pdig_d = 1'b1;
            end else if (c == RCP_DOT && !pdot_q && !pexp_q) begin
              pdot_d = 1'b1;
            end else if (c == RCP_EXP && pdig_q && !pexp_q) begin
              pexp_d = 1'b1;
              pprev_e_d = 1'b1;
            end else if (!((c == RCP_PLUS || c == RCP_MINUS) && (plen_q == 4'h0 || pprev_e_q))) begin
              pnum_d = 1'b0;
            end
          end
        end
        default: begin
          if (d == RCP_SEMI) begin
            st_d = RCP_P_START;
          end
        end
      endcase
      if (feed) begin
        for (int k = 1; k <= RCP_NKW; k++) begin
          hit_d[k] = hit_d[k] && len_d < RCP_KW[k].llen && c == kw_char(k, len_d);
        end
        len_d = len_d + 4'h1;
      end
      if (fin) begin
        nu = '0;
        nu.valid = 1'b1;
        nu.common = common_q;
        nu.query = query_q;
        nu.code = code_q;
        nu.node = node_q;
        if (pnum_q && pdig_q) begin
          nu.pclass = pexp_q ? RCP_PC_NR3 : (pdot_q ? RCP_PC_NR2 : RCP_PC_NR1);
        end else if (plen_q == 4'h2 && pword_q[15:0] == 16'h4f4e) begin
          nu.pclass = RCP_PC_ON;
        end else if (plen_q == 4'h3 && pword_q == 24'h4f4646) begin
          nu.pclass = RCP_PC_OFF;
        end else begin
          nu.pclass = (plen_q == 4'h0) ? RCP_PC_NONE : RCP_PC_CHR;
        end
        if (st_q == RCP_P_HDR && !common_q) begin
          if (found) begin
            nu.node = fidx;
          end else begin
            bad = 1'b1;
          end
        end
        if (!bad) begin
          if (!common_q) begin
            for (int j = 1; j <= RCP_NKW; j++) begin
              if (RCP_KW[j].opt && RCP_KW[j].parent == nu.node) nu.node = 4'(j);
            end
            level_d = parent_of(nu.node);
          end
          if (!common_q && !query_q && RCP_KW[nu.node].coupled) begin
            pend_d = nu;
            cmd_d = pend_q;
          end else begin
            cmd_d = nu;
          end
        end
        st_d = RCP_P_START;
      end
      if (bad) begin
        cmd_err_d = 1'b1;
        st_d = RCP_P_SKIP;
      end
      if (term) begin
        st_d = RCP_P_START;
        msg_start_d = 1'b1;
        level_d = RCP_ROOT;
        rel_d = 1'b1;
      end
    end
    // Coupled unit released one cycle after the terminator
    if (rel_q && pend_q.valid) begin
      cmd_d = pend_q;
      pend_d = '0;
    end
  end

  // Parser registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= RCP_P_START; hit_q <= '1; len_q <= 4'h0; node_q <= RCP_ROOT; level_q <= RCP_ROOT;
      msg_start_q <= 1'b1; eoi_pend_q <= 1'b0; rel_q <= 1'b0; query_q <= 1'b0; common_q <= 1'b0;
      code_q <= '0; pdig_q <= 1'b0; pdot_q <= 1'b0; pexp_q <= 1'b0; pnum_q <= 1'b1; pprev_e_q <= 1'b0;
      plen_q <= 4'h0; pword_q <= '0; pend_q <= '0; cmd_q <= '0; cmd_err_q <= 1'b0;
      query_int_q <= 1'b0; rx_ready_q <= 1'b1;
    end else begin
      st_q <= st_d; hit_q <= hit_d; len_q <= len_d; node_q <= node_d; level_q <= level_d;
      msg_start_q <= msg_start_d; eoi_pend_q <= eoi_pend_d; rel_q <= rel_d; query_q <= query_d;
      common_q <= common_d; code_q <= code_d; pdig_q <= pdig_d; pdot_q <= pdot_d; pexp_q <= pexp_d;
      pnum_q <= pnum_d; pprev_e_q <= pprev_e_d; plen_q <= plen_d; pword_q <= pword_d; pend_q <= pend_d;
      cmd_q <= cmd_d; cmd_err_q <= cmd_err_d; query_int_q <= query_int_d; rx_ready_q <= rx_ready_d;
    end
  end

  // Response buffer and transmitter next state
  always_comb begin
    logic rd;
    tst_d = tst_q; wr_d = wr_q; rd_d = rd_q; crd_d = crd_q; done_d = done_q; tx_d = tx_q; rd = 1'b0;
    we = resp.valid && resp_ready_q && !(resp.crd && crd_q >= RCP_CRD_MAX);
    if (resp.valid && resp_ready_q) begin
      crd_d = (resp.last) ? 5'h00 : crd_q + 5'h01;
      done_d = done_q || resp.last;
    end
    if (we) begin
      wr_d = wr_q + 1'b1;
    end
    case (tst_q)
      RCP_T_IDLE: begin
        if (cnt_q != 5'h00) begin
          tst_d = RCP_T_RD;
        end else if (done_q) begin
          tx_d = '{valid: 1'b1, data: RCP_NL, eoi: !ser_q[1]};
          done_d = 1'b0;
          tst_d = RCP_T_NL;
        end
      end
      RCP_T_RD: begin
        tx_d = '{valid: 1'b1, data: rdata_q, eoi: 1'b0};
        tst_d = RCP_T_OUT;
      end
      default: begin
        if (tx_ready) begin
          tx_d = '0;
          rd = (tst_q == RCP_T_OUT);
          tst_d = RCP_T_IDLE;
        end
      end
    endcase
    if (rd) begin
      rd_d = rd_q + 1'b1;
    end
    cnt_d = cnt_q + {4'h0, we} - {4'h0, rd};
    // Unread response discarded when a new message starts
    if (query_int_d) begin
      tst_d = RCP_T_IDLE; wr_d = '0; rd_d = '0; cnt_d = 5'h00; crd_d = 5'h00; done_d = 1'b0; tx_d = '0;
    end
    resp_ready_d = cnt_d != RCP_BUF_FULL;
  end

  // Response buffer and transmitter registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tst_q <= RCP_T_IDLE; wr_q <= '0; rd_q <= '0; cnt_q <= 5'h00; crd_q <= 5'h00;
      done_q <= 1'b0; tx_q <= '0; resp_ready_q <= 1'b1;
    end else begin
      tst_q <= tst_d; wr_q <= wr_d; rd_q <= rd_d; cnt_q <= cnt_d; crd_q <= crd_d;
      done_q <= done_d; tx_q <= tx_d; resp_ready_q <= resp_ready_d;
    end
  end

  rcp_buf u_buf (
    .clk     (clk),
    .we      (we),
    .waddr   (wr_q),
    .wdata   (resp.data),
    .raddr   (rd_q),
    .rdata_q (rdata_q)
  );

  // Pin synchronisers, local/remote state, serial poll and service request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      keys_s1_q <= '0; keys_s2_q <= '0; ret_q <= '0; ser_q <= '0;
      remote_q <= 1'b0; remote_ind_q <= 1'b0; panel_keys_q <= '0;
      poll_data_q <= '0; poll_valid_q <= 1'b0; srq_q <= 1'b0;
    end else begin
      keys_s1_q <= panel_keys;
      keys_s2_q <= keys_s1_q;
      ret_q <= {ret_q[1:0], key_return};
      ser_q <= {ser_q[1:0], serial_mode};
      if (go_local || (ret_q[1] && !ret_q[2])) begin
        remote_q <= 1'b0;
        remote_ind_q <= 1'b0;
      end else if (go_remote) begin
        remote_q <= 1'b1;
        remote_ind_q <= 1'b1;
      end
      panel_keys_q <= remote_q ? 8'h00 : keys_s2_q;
      srq_q <= |(status_byte & srq_enable & 8'hbf);
      poll_valid_q <= poll_req;
      if (poll_req) begin
        poll_data_q <= {status_byte[7], |(status_byte & srq_enable & 8'hbf), status_byte[5:0]};
      end
    end
  end
endmodule

// >>> logic/rcp_pkg.sv
// Shared constants, command tree table and carrier types of the remote command parser
package rcp_pkg;

  // Character codes the parser recognises
  localparam logic [7:0] RCP_NL    = 8'h0a;
  localparam logic [7:0] RCP_SP    = 8'h20;
  localparam logic [7:0] RCP_STAR  = 8'h2a;
  localparam logic [7:0] RCP_PLUS  = 8'h2b;
  localparam logic [7:0] RCP_MINUS = 8'h2d;
  localparam logic [7:0] RCP_DOT   = 8'h2e;
  localparam logic [7:0] RCP_COLON = 8'h3a;
  localparam logic [7:0] RCP_SEMI  = 8'h3b;
  localparam logic [7:0] RCP_QM    = 8'h3f;
  localparam logic [7:0] RCP_EXP   = 8'h45;

  // Response buffer geometry and character-response limit
  localparam int         RCP_BUF_AW    = 4;
  localparam int         RCP_BUF_DEPTH = 16;
  localparam logic [4:0] RCP_BUF_FULL  = 5'h10;
  localparam logic [4:0] RCP_CRD_MAX   = 5'h0c;

  // Command tree: node 0 is the root, nodes 1..RCP_NKW are keywords
  localparam int         RCP_NKW  = 13;
  localparam logic [3:0] RCP_ROOT = 4'h0;

  typedef struct packed {
    logic [95:0] name;     // Long form, upper case, right aligned
    logic [3:0]  slen;     // Length of the short form
    logic [3:0]  llen;     // Length of the long form
    logic [3:0]  parent;   // Parent node
    logic        opt;      // Node may be omitted
    logic        coupled;  // Non-query execution deferred to the next coupled non-query unit or the terminator
  } rcp_kw_t;

  localparam rcp_kw_t RCP_KW [1:RCP_NKW] = '{
    '{96'("OUTPUT"),     4'h4, 4'h6, 4'h0, 1'b0, 1'b0},
    '{96'("PROTECTION"), 4'h4, 4'ha, 4'h1, 1'b0, 1'b0},
    '{96'("CLEAR"),      4'h3, 4'h5, 4'h2, 1'b0, 1'b0},
    '{96'("STATE"),      4'h4, 4'h5, 4'h1, 1'b1, 1'b0},
    '{96'("VOLTAGE"),    4'h4, 4'h7, 4'h0, 1'b0, 1'b0},
    '{96'("AC"),         4'h2, 4'h2, 4'h5, 1'b0, 1'b1},
    '{96'("DC"),         4'h2, 4'h2, 4'h5, 1'b0, 1'b1},
    '{96'("RANGE"),      4'h4, 4'h5, 4'h5, 1'b0, 1'b1},
    '{96'("FREQUENCY"),  4'h4, 4'h9, 4'h0, 1'b0, 1'b1},
    '{96'("FETCH"),      4'h4, 4'h5, 4'h0, 1'b0, 1'b0},
    '{96'("MEASURE"),    4'h4, 4'h7, 4'h0, 1'b0, 1'b0},
    '{96'("SCALAR"),     4'h4, 4'h6, 4'ha, 1'b1, 1'b0},
    '{96'("CURRENT"),    4'h4, 4'h7, 4'hc, 1'b0, 1'b0}
  };

  // Parameter data classes
  typedef enum logic [2:0] {
    RCP_PC_NONE = 3'h0,
    RCP_PC_NR1  = 3'h1,
    RCP_PC_NR2  = 3'h2,
    RCP_PC_NR3  = 3'h3,
    RCP_PC_ON   = 3'h4,
    RCP_PC_OFF  = 3'h5,
    RCP_PC_CHR  = 3'h6
  } rcp_pclass_t;

  // Parser states
  typedef enum logic [4:0] {
    RCP_P_START = 5'b00001,
    RCP_P_HDR   = 5'b00010,
    RCP_P_SP    = 5'b00100,
    RCP_P_DATA  = 5'b01000,
    RCP_P_SKIP  = 5'b10000
  } rcp_pstate_t;

  // Response transmitter states
  typedef enum logic [3:0] {
    RCP_T_IDLE = 4'b0001,
    RCP_T_RD   = 4'b0010,
    RCP_T_OUT  = 4'b0100,
    RCP_T_NL   = 4'b1000
  } rcp_tstate_t;

  // Received byte from the bus handshake logic
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       eoi;
  } rcp_rx_t;

  // Transmitted byte towards the bus handshake logic
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       eoi;
  } rcp_tx_t;

  // Response byte from the command executor
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       crd;   // Character response, limited in length
    logic       last;
  } rcp_resp_t;

  // Decoded message unit handed to the executor
  typedef struct packed {
    logic        valid;
    logic        common;
    logic        query;
    logic [3:0]  node;
    logic [23:0] code;
    rcp_pclass_t pclass;
  } rcp_cmd_t;

endpackage

// >>> logic/rcp_buf.sv
// Response byte memory with registered read data
`timescale 1ns/100ps
module rcp_buf (
  input  wire logic                          clk,
  input  wire logic                          we,
  input  wire logic [rcp_pkg::RCP_BUF_AW-1:0] waddr,
  input  wire logic [7:0]                    wdata,
  input  wire logic [rcp_pkg::RCP_BUF_AW-1:0] raddr,
  output logic      [7:0]                    rdata_q
);
  import rcp_pkg::*;

  logic [7:0] mem [RCP_BUF_DEPTH];

  // Write port and registered read port
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata_q <= mem[raddr];
  end
endmodule

// >>> tb/rcp_parser_assertions.sv
// Concurrent checks on the parser ports
`timescale 1ns/100ps
module rcp_parser_assertions (
  input wire logic              clk,
  input wire logic              nrst,
  input wire rcp_pkg::rcp_rx_t  rx,
  input wire logic              rx_ready_q,
  input wire rcp_pkg::rcp_cmd_t cmd_q,
  input wire logic              cmd_err_q,
  input wire logic              query_int_q,
  input wire rcp_pkg::rcp_tx_t  tx_q,
  input wire logic              tx_ready,
  input wire logic [7:0]        status_byte,
  input wire logic [7:0]        srq_enable,
  input wire logic              poll_req,
  input wire logic [7:0]        poll_data_q,
  input wire logic              poll_valid_q,
  input wire logic              srq_q,
  input wire logic              key_return,
  input wire logic [7:0]        panel_keys_q,
  input wire logic              remote_q,
  input wire logic              remote_ind_q
);
  import rcp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Service request and poll answers
  property p_srq; 1'b1 |=> srq_q == $past(|(status_byte & srq_enable & 8'hbf)); endproperty
  a_srq: assert property (p_srq) else $error("srq wrong");
  property p_poll;
    poll_req |=> poll_valid_q && poll_data_q[5:0] == $past(status_byte[5:0]) && poll_data_q[7] == $past(status_byte[7]);
  endproperty
  a_poll: assert property (p_poll) else $error("poll answer wrong");
  property p_poll_once; !poll_req |=> !poll_valid_q; endproperty
  a_poll_once: assert property (p_poll_once) else $error("poll valid unasked");
  // Remote state blocks keys and lights the indicator
  property p_keys; remote_q && $past(remote_q) |-> panel_keys_q == 8'h00; endproperty
  a_keys: assert property (p_keys) else $error("keys pass in remote");
  property p_ind; $stable(remote_q) |-> remote_ind_q == remote_q; endproperty
  a_ind: assert property (p_ind) else $error("indicator wrong");
  property p_ret; $rose(key_return) && remote_q |-> ##[1:6] !remote_q; endproperty
  a_ret: assert property (p_ret) else $error("return key ignored");
  // Response framing and holding
  property p_eoi; tx_q.valid && tx_q.eoi |-> tx_q.data == RCP_NL; endproperty
  a_eoi: assert property (p_eoi) else $error("end flag off newline");
  property p_hold; tx_q.valid && !tx_ready |=> query_int_q || tx_q.valid && $stable(tx_q.data); endproperty
  a_hold: assert property (p_hold) else $error("tx byte dropped");
  property p_qi; query_int_q |=> !query_int_q; endproperty
  a_qi: assert property (p_qi) else $error("query int not a pulse");
  property p_rxr; rx.valid && rx.eoi && rx.data != RCP_NL |=> !rx_ready_q; endproperty
  a_rxr: assert property (p_rxr) else $error("ready after end flag");
  // Main scenarios reached
  c_cmd: cover property (cmd_q.valid);
  c_err: cover property (cmd_err_q);
  c_qi: cover property (query_int_q);
  c_poll: cover property (poll_valid_q);
endmodule
bind rcp_parser rcp_parser_assertions rcp_parser_assertions_inst (.clk, .nrst, .rx, .rx_ready_q, .cmd_q,
  .cmd_err_q, .query_int_q, .tx_q, .tx_ready, .status_byte, .srq_enable, .poll_req, .poll_data_q,
  .poll_valid_q, .srq_q, .key_return, .panel_keys_q, .remote_q, .remote_ind_q);

// >>> tb/rcp_ctrl_model.sv
// Bus controller model that takes response bytes
`timescale 1ns/100ps
module rcp_ctrl_model (
  input  wire logic             clk,
  input  wire rcp_pkg::rcp_tx_t tx_q,
  input  wire logic             stall,
  output logic                  tx_ready
);
  import rcp_pkg::*;
  logic [8:0] got [$];
  // Ready moves on the falling edge only; stall models a slow reader
  initial tx_ready = 1'b0;
  always @(negedge clk) tx_ready <= !stall;
  // Each byte is taken whole with its end flag on the accepting edge
  always @(posedge clk) begin
    if (tx_q.valid && tx_ready) got.push_back({tx_q.eoi, tx_q.data});
  end
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the remote command parser
`timescale 1ns/100ps
module tb_top;
  import rcp_pkg::*;
  logic       clk = 1'b0, nrst = 1'b0, serial_mode = 1'b0, poll_req = 1'b0, go_remote = 1'b0;
  logic       go_local = 1'b0, key_return = 1'b0, stall = 1'b0;
  logic [7:0] status_byte = '0, srq_enable = '0, panel_keys = '0, poll_data_q, panel_keys_q;
  logic       rx_ready_q, cmd_err_q, query_int_q, resp_ready_q, poll_valid_q, srq_q, remote_q;
  logic       remote_ind_q, tx_ready;
  rcp_rx_t    rx = '0;
  rcp_resp_t  resp = '0;
  rcp_cmd_t   cmd_q, last_cmd;
  rcp_tx_t    tx_q;
  int         n_errors = 0, n_tests = 0, n_cmd = 0, n_err = 0, n_qi = 0;
  always #5 clk = ~clk;
  rcp_parser rcp_parser_inst (.clk, .nrst, .rx, .rx_ready_q, .cmd_q, .cmd_err_q, .query_int_q, .resp,
    .resp_ready_q, .tx_q, .tx_ready, .serial_mode, .status_byte, .srq_enable, .poll_req, .poll_data_q,
    .poll_valid_q, .srq_q, .go_remote, .go_local, .panel_keys, .key_return, .panel_keys_q, .remote_q,
    .remote_ind_q);
  rcp_ctrl_model rcp_ctrl_model_inst (.clk, .tx_q, .stall, .tx_ready);
  // Count decoded units, errors and interrupted queries
  always @(posedge clk) begin
    if (cmd_q.valid === 1'b1) begin
      n_cmd++;
      last_cmd = cmd_q;
    end
    if (cmd_err_q === 1'b1) n_err++;
    if (query_int_q === 1'b1) n_qi++;
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One byte a cycle; the end flag rides the last byte if asked
  task send(input string s, input bit e);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk);
      rx = '{1'b1, s[i], e && (i == s.len() - 1)};
    end
    @(negedge clk);
    rx = '{1'b0, ~rx.data, 1'b0};
  endtask
  task unit(input string s, input bit e, input int nc, input int ne, input logic [3:0] nd, input rcp_pclass_t pc);
    int c0, e0;
    c0 = n_cmd;
    e0 = n_err;
    send(s, e);
    tick(4);
    chk("units", nc, n_cmd - c0);
    chk("errors", ne, n_err - e0);
    if (nc > 0) chk("node", 32'(nd), 32'(last_cmd.node));
    if (nc > 0) chk("class", 32'(pc), 32'(last_cmd.pclass));
  endtask
  // Executor bytes held until the parser takes them
  task push(input string s, input bit crd);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clk);
      resp = '{1'b1, s[i], crd, i == s.len() - 1};
      do @(posedge clk); while (resp_ready_q !== 1'b1);
    end
    @(negedge clk);
    resp = '0;
  endtask
  task t_reset;
    panel_keys = 8'h5a;
    tick(4);
    chk("rx_ready", 1, 32'(rx_ready_q));
    chk("resp_ready", 1, 32'(resp_ready_q));
    chk("remote", 0, 32'(remote_q));
    chk("keys", 8'h5a, 32'(panel_keys_q));
    $display("test reset done");
  endtask
  task t_remote;
    go_remote = 1'b1;
    tick(1);
    go_remote = 1'b0;
    tick(4);
    chk("remote", 1, 32'(remote_q));
    chk("indicator", 1, 32'(remote_ind_q));
    chk("keys", 0, 32'(panel_keys_q));
    key_return = 1'b1;
    tick(8);
    chk("remote", 0, 32'(remote_q));
    chk("indicator", 0, 32'(remote_ind_q));
    key_return = 1'b0;
    go_remote = 1'b1;
    tick(1);
    go_remote = 1'b0;
    go_local = 1'b1;
    tick(1);
    go_local = 1'b0;
    chk("local", 0, 32'(remote_q));
    $display("test remote done");
  endtask
  task t_srq;
    status_byte = 8'h50;
    srq_enable = 8'h40;
    tick(3);
    chk("srq", 0, 32'(srq_q));
    status_byte = 8'h10;
    srq_enable = 8'h10;
    tick(3);
    chk("srq", 1, 32'(srq_q));
    poll_req = 1'b1;
    tick(1);
    chk("poll_valid", 1, 32'(poll_valid_q));
    chk("poll_data", 8'h50, 32'(poll_data_q));
    poll_req = 1'b0;
    srq_enable = 8'h00;
    $display("test srq done");
  endtask
  task t_cmds;
    unit("FREQ 1.5\n", 0, 1, 0, 4'h9, RCP_PC_NR2);
    unit("freq 15\n", 1, 1, 0, 4'h9, RCP_PC_NR1);
    unit("FREQUENCY 1.5E+2", 1, 1, 0, 4'h9, RCP_PC_NR3);
    unit("OUTP:PROT:CLE;CLE\n", 0, 2, 0, 4'h3, RCP_PC_NONE);
    unit("OUTP:STAT OFF\n", 0, 1, 0, 4'h4, RCP_PC_OFF);
    unit("OUTP ON\n", 0, 1, 0, 4'h4, RCP_PC_ON);
    unit("VOLT:AC 2;:FETC:CURR?\n", 0, 2, 0, 4'h6, RCP_PC_NR1);
    unit("\n", 0, 0, 0, 4'h0, RCP_PC_NONE);
    unit("OUTPU 1\n", 0, 0, 1, 4'h0, RCP_PC_NONE);
    unit("BOGUS 1\n", 0, 0, 1, 4'h0, RCP_PC_NONE);
    unit("FREQ1.5\n", 0, 0, 1, 4'h0, RCP_PC_NONE);
    send("*CLS\n", 0);
    tick(4);
    chk("common", 1, 32'(last_cmd.common));
    chk("code", 32'h00434c53, 32'(last_cmd.code));
    $display("test commands done");
  endtask
  task t_resp(input string s, input bit crd, input bit ser, input int n);
    serial_mode = ser;
    tick(4);
    rcp_ctrl_model_inst.got.delete();
    push(s, crd);
    for (int k = 0; k < 100 && rcp_ctrl_model_inst.got.size() < n + 1; k++) tick(1);
    chk("resp_len", n + 1, rcp_ctrl_model_inst.got.size());
    for (int i = 0; i < n; i++) chk("resp_byte", 32'({1'b0, s[i]}), 32'(rcp_ctrl_model_inst.got[i]));
    chk("resp_end", 32'({!ser, RCP_NL}), 32'(rcp_ctrl_model_inst.got[n]));
    $display("test response done");
  endtask
  task t_qi;
    int q0;
    q0 = n_qi;
    stall = 1'b1;
    push("XY", 1'b0);
    tick(4);
    send("*CLS\n", 0);
    tick(4);
    chk("query_int", 1, n_qi - q0);
    stall = 1'b0;
    tick(10);
    $display("test interrupted query done");
  endtask
  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Main sequence after the reset span
  initial begin
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    t_reset;
    t_remote;
    t_srq;
    t_cmds;
    t_resp("0.5", 1'b0, 1'b0, 3);
    t_resp("ABCDEFGHIJKLM", 1'b1, 1'b1, 12);
    t_resp("ABCDEFGHIJKLMN", 1'b0, 1'b0, 14);
    t_qi;
    tally_and_finish;
  end
  // Watchdog well beyond the expected run
  initial begin
    #100us;
    n_errors++;
    tally_and_finish;
  end
endmodule
